// File: common/acc_pkg.sv
package acc_pkg;

  // Register byte addresses on the Wishbone slave.
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CHAN    = 8'h04;
  localparam logic [7:0] ADDR_REF     = 8'h08;
  localparam logic [7:0] ADDR_CLKDIV  = 8'h0c;
  localparam logic [7:0] ADDR_IRQ     = 8'h10;
  localparam logic [7:0] ADDR_RESULT  = 8'h14;
  localparam logic [7:0] ADDR_STATUS  = 8'h18;

  // Control register bit positions.
  localparam int CTRL_ON_BIT   = 0;
  localparam int CTRL_GO_BIT   = 1;
  localparam int CTRL_CONT_BIT = 2;
  localparam int CTRL_CS_BIT   = 3;
  localparam int CTRL_FM_BIT   = 4;
  localparam int CTRL_SLEEP_BIT = 5;

  // Interrupt register bit positions.
  localparam int IRQ_FLAG_BIT  = 0;
  localparam int IRQ_EN_BIT    = 1;
  localparam int IRQ_PERIPHERAL_IRQ_ENABLE_BIT  = 2;
  localparam int IRQ_GIE_BIT   = 3;

  // Reference register fields.
  localparam int REF_NREF_BIT  = 4;

  // Channel codes.
  localparam logic [5:0] CH_LAST_PIN = 6'h22;
  localparam logic [5:0] CH_AGND     = 6'h3c;
  localparam logic [5:0] CH_TEMP     = 6'h3d;
  localparam logic [5:0] CH_DAC      = 6'h3e;
  localparam logic [5:0] CH_FVR      = 6'h3f;

  // Positive reference codes.
  localparam logic [2:0] PREF_VDD    = 3'h0;
  localparam logic [2:0] PREF_PIN    = 3'h1;
  localparam logic [2:0] PREF_FVR1   = 3'h2;
  localparam logic [2:0] PREF_FVR2   = 3'h3;
  localparam logic [2:0] PREF_FVR4   = 3'h4;

  // Conversion length: 11.5 periods counted in half periods.
  localparam int HALF_PERIODS = 23;
  localparam int RESULT_W     = 10;

  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_CONV = 2'b01,
    ACC_DONE = 2'b11
  } acc_state_t;

  typedef struct packed {
    logic [5:0] chan;
    logic [2:0] pref;
    logic       nref_pin;
  } acc_analog_t;

endpackage

// File: src/acc_clkdiv.sv
`timescale 1ns/10ps
module acc_clkdiv
  import acc_pkg::*;
#(
  parameter int DIV_W = 6
) (
  input  wire logic             clk_i,     // System clock.
  input  wire logic             rst_i,     // Synchronous reset.
  input  wire logic [DIV_W-1:0] div_i,     // Divider code.
  input  wire logic             restart_i, // Restart count.
  output logic                  tick_o     // Half-period tick.
);

  initial begin
    if (DIV_W < 1 || DIV_W > 16) begin
      $error("acc_clkdiv: DIV_W out of range");
    end
  end

  // Ratio is 2*code+2, so a half period lasts code+1 system cycles.
  logic [DIV_W-1:0] cnt;

  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i) begin
      cnt <= '0;
    end else if (cnt == div_i) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  assign tick_o = !rst_i && !restart_i && (cnt == div_i);

endmodule // acc_clkdiv

// File: src/acc_top.sv
// How it works
// - Channel codes 0 to 0x22 connect external analog pins in order.
// - Codes 0x3f, 0x3e, 0x3d select fixed reference, DAC, temperature.
// - Code 0x3c selects ground; reserved codes connect nothing.
// - Positive reference chooses pin, supply, or 1.024/2.048/4.096 V.
// - One bit chooses the negative reference pin or ground.
// - Clock source bit one picks internal RC clock, zero picks system.
// - System clock divided by twice the code plus two.
// - A conversion lasts 11.5 bit periods, one bit resolved per period.
// - Control logic runs on the system clock; only engine steps follow the selected clock.
// - Non-RC conversion clock tracks the system clock.
// - Interrupt request only while done flag and enable are both set.
// - Done flag set after every conversion regardless of enable.
// - Conversions proceed in sleep only on the internal RC clock.
// - Enabled completion interrupt wakes the device from sleep.
// - After wake, vector only when global interrupts are enabled.
// - Result stored left or right justified by the format bit.
// - Converter works only while its on bit is set.
// - Completion clears go unless continuous, sets flag, stores result.
// - Clearing go mid-conversion discards the partial result.
// - Format bit one means right justified, zero left justified.
`timescale 1ns/10ps
module acc_top
  import acc_pkg::*;
#(
  parameter int DIV_W = 6
) (
  input  wire logic                clk_i,      // System clock, 250 MHz.
  input  wire logic                rst_i,      // Synchronous reset.
  input  wire logic                wb_cyc_i,   // Wishbone cycle.
  input  wire logic                wb_stb_i,   // Wishbone strobe.
  input  wire logic                wb_we_i,    // Wishbone write enable.
  input  wire logic [7:0]          wb_adr_i,   // Wishbone byte address.
  input  wire logic [3:0]          wb_sel_i,   // Wishbone byte selects.
  input  wire logic [31:0]         wb_dat_i,   // Wishbone write data.
  output logic      [31:0]         wb_dat_o,   // Wishbone read data.
  output logic                     wb_ack_o,   // Wishbone acknowledge.
  input  wire logic                rc_clk_i,   // Internal RC clock, sampled.
  input  wire logic                sar_bit_i,  // Comparator decision.
  output logic      [RESULT_W-1:0] sar_trial_o, // Trial code to DAC.
  output logic                     sample_o,   // Sample-and-hold acquiring.
  output acc_analog_t              analog_o,   // Mux and reference selects.
  output logic                     pin_sel_o,  // Channel is an external pin.
  output logic                     connect_o,  // Any channel connected.
  input  wire logic                sleep_i,    // Device in sleep.
  output logic                     irq_o,      // Peripheral interrupt request.
  output logic                     wake_o,     // Wake from sleep.
  output logic                     vector_o    // Take the service routine.
);

  initial begin
    if (DIV_W != 6) begin
      $error("acc_top: divider field must be six bits");
    end
  end

  // Software-visible state.
  logic             conv_on;
  logic             conv_go;
  logic             cont_mode;
  logic             clk_src_rc;
  logic             justify_right;
  logic [5:0]       chan;
  logic [2:0]       pref;
  logic             nref_pin;
  logic [DIV_W-1:0] clk_div;
  logic             done_flag;
  logic             irq_en;
  logic             periph_en;
  logic             global_en;
  logic [15:0]      result;

  // Conversion engine state.
  acc_state_t       state;
  logic [4:0]       half_cnt;
  logic [RESULT_W-1:0] sar_reg;
  logic [3:0]       bit_idx;

  logic wr_stb;
  logic rd_hit;
  logic wr_ctrl;
  logic wr_irq;
  logic go_clear;
  logic conv_end;
  logic tick;
  logic div_tick;
  logic rc_s1;
  logic rc_s2;
  logic rc_s3;
  logic rc_tick;
  logic restart;
  logic [DIV_W-1:0] prev_div;
  logic             prev_src;
  logic [RESULT_W-1:0] final_val;

  assign wr_stb  = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
  assign wr_ctrl = wr_stb && (wb_adr_i == ADDR_CTRL);
  assign wr_irq  = wr_stb && (wb_adr_i == ADDR_IRQ);

  // One-cycle ack after each request, dropped the cycle after.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // Configuration registers.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_on       <= 1'b0;
      cont_mode     <= 1'b0;
      clk_src_rc    <= 1'b0;
      justify_right <= 1'b0;
      chan          <= '0;
      pref          <= PREF_VDD;
      nref_pin      <= 1'b0;
      clk_div       <= '0;
      irq_en        <= 1'b0;
      periph_en     <= 1'b0;
      global_en     <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        conv_on       <= wb_dat_i[CTRL_ON_BIT];
        cont_mode     <= wb_dat_i[CTRL_CONT_BIT];
        clk_src_rc    <= wb_dat_i[CTRL_CS_BIT];
        justify_right <= wb_dat_i[CTRL_FM_BIT];
      end
      if (wr_stb && wb_adr_i == ADDR_CHAN) begin
        chan <= wb_dat_i[5:0];
      end
      if (wr_stb && wb_adr_i == ADDR_REF) begin
        pref     <= wb_dat_i[2:0];
        nref_pin <= wb_dat_i[REF_NREF_BIT];
      end
      if (wr_stb && wb_adr_i == ADDR_CLKDIV) begin
        clk_div <= wb_dat_i[DIV_W-1:0];
      end
      if (wr_irq) begin
        irq_en    <= wb_dat_i[IRQ_EN_BIT];
        periph_en <= wb_dat_i[IRQ_PERIPHERAL_IRQ_ENABLE_BIT];
        global_en <= wb_dat_i[IRQ_GIE_BIT];
      end
    end
  end

  // Go bit: software sets or clears it, hardware clears it at the end unless continuous.
  assign go_clear = wr_ctrl && !wb_dat_i[CTRL_GO_BIT];

  // The on bit written together with go decides, so one write can start from off.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      conv_go <= 1'b0;
    end else if (go_clear) begin
      conv_go <= 1'b0;
    end else if (wr_ctrl) begin
      conv_go <= wb_dat_i[CTRL_ON_BIT];
    end else if (!conv_on) begin
      conv_go <= 1'b0;
    end else if (conv_end && !cont_mode) begin
      conv_go <= 1'b0;
    end
  end

  // Done flag: set wins over a software clear; never cleared by hardware.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_flag <= 1'b0;
    end else if (conv_end) begin
      done_flag <= 1'b1;
    end else if (wr_irq && !wb_dat_i[IRQ_FLAG_BIT]) begin
      done_flag <= 1'b0;
    end
  end

  // RC clock is sampled through two flops; the third only feeds edge detect.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rc_s1 <= 1'b0;
      rc_s2 <= 1'b0;
      rc_s3 <= 1'b0;
    end else begin
      rc_s1 <= rc_clk_i;
      rc_s2 <= rc_s1;
      rc_s3 <= rc_s2;
    end
  end

  // Each synchronized RC edge gives exactly one half-period tick.
  assign rc_tick = rc_s2 ^ rc_s3;

  // Divider restarts whenever its field or the source changes.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_div <= '0;
      prev_src <= 1'b0;
    end else begin
      prev_div <= clk_div;
      prev_src <= clk_src_rc;
    end
  end

  assign restart = (prev_div != clk_div) || (prev_src != clk_src_rc);

  acc_clkdiv #(
    .DIV_W(DIV_W)
  ) u_div (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .div_i    (clk_div),
    .restart_i(restart),
    .tick_o   (div_tick)
  );

  // Engine steps on the selected clock; the divided tick tracks clk_i.
  assign tick = clk_src_rc ? rc_tick : div_tick;

  // Successive approximation: acquire for three half periods, then one
  // bit per period, finishing after 23 half periods in all.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state    <= ACC_IDLE;
      half_cnt <= '0;
      sar_reg  <= '0;
      bit_idx  <= '0;
    end else begin
      case (state)
        ACC_IDLE: begin
          half_cnt <= '0;
          bit_idx  <= 4'(RESULT_W - 1);
          sar_reg  <= '0;
          // Non-RC sources stall while asleep.
          if (conv_go && conv_on && (clk_src_rc || !sleep_i)) begin
            state <= ACC_CONV;
          end
        end
        ACC_CONV: begin
          if (!conv_go || !conv_on) begin
            state <= ACC_IDLE;
          end else if (tick && !(sleep_i && !clk_src_rc)) begin
            half_cnt <= half_cnt + 5'd1;
            if (half_cnt >= 5'd3 && half_cnt[0]) begin
              sar_reg[bit_idx] <= sar_bit_i;
              bit_idx <= bit_idx - 4'd1;
            end
            if (half_cnt == 5'(HALF_PERIODS - 1)) begin
              state <= ACC_DONE;
            end
          end
        end
        ACC_DONE: begin
          state <= ACC_IDLE;
        end
        default: begin
          state <= ACC_IDLE;
        end
      endcase
    end
  end

  assign conv_end  = (state == ACC_DONE);
  assign final_val = sar_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result <= '0;
    end else if (conv_end) begin
      if (justify_right) begin
        result <= {6'h00, final_val};
      end else begin
        result <= {final_val, 6'h00};
      end
    end
  end

  // Trial code drives the internal DAC: decided bits plus the bit under test.
  always_comb begin
    sar_trial_o = sar_reg;
    if (state == ACC_CONV && half_cnt >= 5'd3 && bit_idx < 4'(RESULT_W)) begin
      sar_trial_o[bit_idx] = 1'b1;
    end
  end

  assign sample_o = (state == ACC_CONV) && (half_cnt < 5'd3);

  // Analog selection outputs.
  assign analog_o.chan     = chan;
  assign analog_o.pref     = pref;
  assign analog_o.nref_pin = nref_pin;
  assign pin_sel_o = (chan <= CH_LAST_PIN);
  assign connect_o = (chan <= CH_LAST_PIN) || (chan >= CH_AGND);

  // Interrupt, wake and vectoring.
  assign irq_o    = done_flag && irq_en;
  assign wake_o   = sleep_i && irq_o;
  assign vector_o = irq_o && periph_en && global_en;

  // Read data is registered with the ack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (rd_hit) begin
      case (wb_adr_i)
        ADDR_CTRL: begin
          wb_dat_o <= {26'h0, sleep_i, justify_right, clk_src_rc, cont_mode,
                       conv_go, conv_on};
        end
        ADDR_CHAN: begin
          wb_dat_o <= {26'h0, chan};
        end
        ADDR_REF: begin
          wb_dat_o <= {27'h0, nref_pin, 1'b0, pref};
        end
        ADDR_CLKDIV: begin
          wb_dat_o <= {26'h0, clk_div};
        end
        ADDR_IRQ: begin
          wb_dat_o <= {28'h0, global_en, periph_en, irq_en, done_flag};
        end
        ADDR_RESULT: begin
          wb_dat_o <= {16'h0, result};
        end
        ADDR_STATUS: begin
          wb_dat_o <= {30'h0, state};
        end
        default: begin
          wb_dat_o <= '0;
        end
      endcase
    end
  end

  assign rd_hit = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;

endmodule // acc_top

// File: verification/acc_sar_model.sv
`timescale 1ns/10ps
module acc_sar_model
  import acc_pkg::*;
(
  input  wire logic [RESULT_W-1:0] trial_i,  // Trial code.
  input  wire logic [RESULT_W-1:0] vin_i,    // Held input level.
  output logic                     bit_o,    // Comparator decision.
  output logic                     rc_clk_o  // Free-running RC clock.
);
  // The RC clock runs free and is unrelated in phase to the system clock.
  initial rc_clk_o = 1'b0;
  always #13 rc_clk_o = ~rc_clk_o;
  assign bit_o = (vin_i >= trial_i);
endmodule // acc_sar_model

// File: verification/acc_top_monitor.sv
`timescale 1ns/10ps
module acc_top_monitor
  import acc_pkg::*;
(
  input wire logic        clk_i,     // Clock.
  input wire logic        rst_i,     // Reset.
  input wire logic        wb_cyc_i,  // Cycle.
  input wire logic        wb_stb_i,  // Strobe.
  input wire logic        wb_we_i,   // Write.
  input wire logic        wb_ack_o,  // Acknowledge.
  input wire acc_analog_t analog_o,  // Selects.
  input wire logic        pin_sel_o, // Pin channel.
  input wire logic        connect_o, // Connected.
  input wire logic        sleep_i,   // Sleep.
  input wire logic        irq_o,     // Request.
  input wire logic        wake_o,    // Wake.
  input wire logic        vector_o   // Vector.
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_follows_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not acknowledged");
  a_irq_sw_clear: assert property (
    $fell(irq_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("irq dropped without a write");
  a_wake_from_irq: assert property (wake_o == (sleep_i && irq_o))
    else $error("wake mismatch");
  a_vector_needs_irq: assert property (vector_o |-> irq_o)
    else $error("vector without irq");
  a_pin_range: assert property (pin_sel_o == (analog_o.chan <= 6'h22))
    else $error("pin select mismatch");
  a_reserved_open: assert property (
    connect_o == !(analog_o.chan inside {[6'h23:6'h3b]}))
    else $error("connect mismatch");
  a_select_hold: assert property (
    $changed(analog_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
    else $error("selects changed without a write");
endmodule // acc_top_monitor

bind acc_top acc_top_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .analog_o(analog_o),
  .pin_sel_o(pin_sel_o), .connect_o(connect_o), .sleep_i(sleep_i), .irq_o(irq_o),
  .wake_o(wake_o), .vector_o(vector_o));

// File: verification/tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb;
  import acc_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        sleep = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q, rdat;
  logic [9:0]  vin = 10'h0;
  logic [9:0]  trial;
  logic [15:0] last_exp;
  logic [5:0]  c;
  logic        bit_c, rc, ack, pin_sel, conn, irq, wake, vec, smp;
  acc_analog_t ana;
  logic [5:0]  cods [8] = '{6'h00, 6'h22, 6'h23, 6'h3b, 6'h3c, 6'h3d, 6'h3e, 6'h3f};
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          seed = 94279;
  int          cycles = 0;
  int          n;
  always #2 clk_i = ~clk_i;

  acc_top DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .rc_clk_i(rc), .sar_bit_i(bit_c), .sar_trial_o(trial), .sample_o(smp), .analog_o(ana),
    .pin_sel_o(pin_sel), .connect_o(conn), .sleep_i(sleep), .irq_o(irq), .wake_o(wake),
    .vector_o(vec));
  acc_sar_model u_sar (.trial_i(trial), .vin_i(vin), .bit_o(bit_c), .rc_clk_o(rc));

  function automatic logic [15:0] exp_res(logic [9:0] v, logic right);
    return right ? {6'h00, v} : {v, 6'h00};
  endfunction

  task automatic close_out();
    $display("tests_run %0d n_mismatch %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wait_go();
    int k;
    k = 0;
    do begin
      wb(ADDR_CTRL, 1'b0, 32'h0);
      k++;
    end while (q[CTRL_GO_BIT] !== 1'b0 && k < 400);
    `CHK(q[CTRL_GO_BIT], 1'b0)
  endtask

  task automatic conv(input int dv, input logic fm, input logic cs);
    vin <= 10'($random(seed));
    wb(ADDR_CLKDIV, 1'b1, 32'(dv));
    wb(ADDR_CTRL, 1'b1, 32'h3 | (32'(fm) << 4) | (32'(cs) << 3));
    n = 0;
    while (smp !== 1'b1 && n < 999) begin
      @(posedge clk_i);
      n++;
    end
    n = 0;
    while (smp === 1'b1 && n < 999) begin
      @(posedge clk_i);
      n++;
    end
    if (!cs)
      `CHK(n > 2 * dv + 1 && n <= 3 * dv + 4, 1'b1)
    wait_go();
    last_exp = exp_res(vin, fm);
    wb(ADDR_RESULT, 1'b0, 32'h0);
    `CHK(q[15:0], last_exp)
    wb(ADDR_IRQ, 1'b0, 32'h0);
    `CHK(q[IRQ_FLAG_BIT], 1'b1)
  endtask

  initial begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(8'h1c, 1'b1, 32'hffff_ffff);
    for (int a = 0; a < 32; a += 4) begin
      wb(8'(a), 1'b0, 32'h0);
      `CHK(q, 32'h0)
    end
    $display("test reset done");
    for (int i = 0; i < 12; i++) begin
      c = (i < 8) ? cods[i] : 6'($random(seed));
      wb(ADDR_CHAN, 1'b1, {26'h0, c});
      `CHK(ana.chan, c)
      `CHK(pin_sel, c <= CH_LAST_PIN)
      `CHK(conn, !(c > CH_LAST_PIN && c < CH_AGND))
    end
    for (int p = 0; p < 5; p++) begin
      wb(ADDR_REF, 1'b1, 32'(p) | (32'(p % 2) << REF_NREF_BIT));
      `CHK(ana.pref, 3'(p))
      `CHK(ana.nref_pin, 1'(p % 2))
    end
    wb(ADDR_CHAN, 1'b1, 32'h0);
    repeat (20) @(posedge clk_i);
    $display("test selects done");
    for (int i = 0; i < 6; i++) begin
      wb(ADDR_IRQ, 1'b1, (i == 2) ? 32'h0 : 32'h2);
      conv($random(seed) & 3, 1'(i), i >= 4);
      `CHK(irq, i != 2)
      wb(ADDR_IRQ, 1'b1, 32'h2);
      `CHK(irq, 1'b0)
    end
    $display("test conversions done");
    vin <= ~vin;
    wb(ADDR_CHAN, 1'b1, {26'h0, CH_AGND});
    wb(ADDR_CTRL, 1'b1, 32'h3);
    n = 0;
    while (smp !== 1'b1 && n < 99) begin
      @(posedge clk_i);
      n++;
    end
    while (smp === 1'b1 && n < 999) begin
      @(posedge clk_i);
      n++;
    end
    wb(ADDR_CTRL, 1'b1, 32'h1);
    wait_go();
    wb(ADDR_RESULT, 1'b0, 32'h0);
    `CHK(q[15:0], last_exp)
    wb(ADDR_CTRL, 1'b1, 32'h7);
    repeat (300) @(posedge clk_i);
    wb(ADDR_CTRL, 1'b0, 32'h0);
    `CHK(q[CTRL_GO_BIT], 1'b1)
    wb(ADDR_IRQ, 1'b0, 32'h0);
    `CHK(q[IRQ_FLAG_BIT], 1'b1)
    wb(ADDR_CTRL, 1'b1, 32'h1);
    wb(ADDR_IRQ, 1'b1, 32'h0);
    $display("test abort and continuous done");
    wb(ADDR_CTRL, 1'b1, 32'h2);
    repeat (100) @(posedge clk_i);
    wb(ADDR_STATUS, 1'b0, 32'h0);
    `CHK(q[1:0], 2'(ACC_IDLE))
    sleep <= 1'b1;
    wb(ADDR_CTRL, 1'b1, 32'h3);
    repeat (200) @(posedge clk_i);
    wb(ADDR_STATUS, 1'b0, 32'h0);
    `CHK(q[1:0], 2'(ACC_IDLE))
    wb(ADDR_IRQ, 1'b0, 32'h0);
    `CHK(q[IRQ_FLAG_BIT], 1'b0)
    wb(ADDR_CTRL, 1'b1, 32'h0);
    wb(ADDR_IRQ, 1'b1, 32'h6);
    wb(ADDR_CTRL, 1'b1, 32'hb);
    wait_go();
    `CHK(wake, 1'b1)
    `CHK(vec, 1'b0)
    wb(ADDR_IRQ, 1'b1, 32'hf);
    `CHK(vec, 1'b1)
    sleep <= 1'b0;
    $display("test sleep done");
    close_out();
  end
endmodule // tb
